// [gpc_pin_ctrl.sv]
// gpc_pin_ctrl: control of one general-purpose pin, AXI4-Lite slave
// assumes pin_in is asynchronous and src comes from logic on aclk
//
// Operation
// - enable 0 tri-states; direction 1 is input
// - pull field: none, down, up, reserved
// - edge mode 0: edge set by polarity
// - edge mode 1: both edges interrupt
// - polarity 0 inverts, 1 passes through
// - output type: push-pull or open drain
// - supply domain bit drives select output
// - input codes 0,1: plain gpio input
// - input codes 2-6: power and sleep requests
// - input codes 7-9: watchdog, voltage scale selects
// - input codes 10-13: hardware enables, controls
// - input codes 14,15: controls, long debounce
// - output codes 0,1: register level, 32k clock
// - output codes 2-4: on, sleep, change states
// - output 6 pen down; 5 reserved
// - output 7-9: conversion done, voltage done
// - output 10,11: external power enables
// - output 12,13: supply good, power good
// - output 14,15: 2 MHz clock, auxiliary reset
//
// Register access over AXI4-Lite was chosen for this implementation.

`timescale 1ns/100ps

module gpc_pin_ctrl
    import gpc_pkg::*;
#(
    parameter int SHORT_DB_CYC = GPC_SHORT_DB_CYC,
    parameter int LONG_DB_CYC  = GPC_LONG_DB_CYC
) (
    input  wire logic        aclk,          // system clock, 20 MHz
    input  wire logic        aresetn,       // synchronous reset, low
    input  wire logic [31:0] awaddr,        // write address
    input  wire logic        awvalid,       // write address valid
    output logic             awready,       // write address ready
    input  wire logic [31:0] wdata,         // write data
    input  wire logic [3:0]  wstrb,         // write byte strobes
    input  wire logic        wvalid,        // write data valid
    output logic             wready,        // write data ready
    output logic [1:0]       bresp,         // write response
    output logic             bvalid,        // write response valid
    input  wire logic        bready,        // write response ready
    input  wire logic [31:0] araddr,        // read address
    input  wire logic        arvalid,       // read address valid
    output logic             arready,       // read address ready
    output logic [31:0]      rdata,         // read data
    output logic [1:0]       rresp,         // read response
    output logic             rvalid,        // read data valid
    input  wire logic        rready,        // read data ready
    input  wire logic        pin_in,        // pin level seen at the pad
    output logic             pin_out,       // level driven on the pad
    output logic             pin_oe,        // pad driver enable
    output logic             pull_up_en,    // pull-up resistor on
    output logic             pull_down_en,  // pull-down resistor on
    output logic             supply_domain_select, // 1: system supply
    input  wire gpc_src_t    src,           // states offered to the pin
    output gpc_req_t         req,           // requests taken from the pin
    output logic             pin_irq        // pin edge event, one cycle
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic        out_level;
        gpc_wr_st_t  wr_st;
        logic [1:0]  wsel;
        logic [15:0] wdat;
        logic [1:0]  wstb;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic        irq;
        logic        pin_o;
        logic        pin_oe;
        gpc_req_t    req;
    } gpc_state_t;

    gpc_state_t st_r;
    gpc_state_t st_nxt;

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic [1:0] gpc_decode(input logic [31:0] addr);
        logic [1:0] sel;
        sel = GPC_SEL_NONE;
        if (addr[31:2] == GPC_CTRL_IDX) begin
            sel = GPC_SEL_CTRL;
        end else if (addr[31:2] == GPC_LEVEL_IDX) begin
            sel = GPC_SEL_LEVEL;
        end else if (addr[31:2] == GPC_STAT_IDX) begin
            sel = GPC_SEL_STAT;
        end
        return sel;
    endfunction

    // codes whose input path uses the long filter
    function automatic logic gpc_long_fn(input logic [3:0] fn);
        return (fn == 4'h0) || (fn == 4'h4) ||
               (fn == 4'he) || (fn == 4'hf);
    endfunction

    function automatic logic gpc_out_mux(input logic [3:0] fn,
                                         input logic       lvl,
                                         input gpc_src_t   s);
        logic o;
        o = 1'b0;
        case (fn)
            4'h0: o = lvl;
            4'h1: o = s.osc_32k;
            4'h2: o = s.on_state;
            4'h3: o = s.sleep_state;
            4'h4: o = s.power_state_change;
            4'h6: o = s.pen_down;
            4'h7: o = s.conv_complete;
            4'h8: o = s.dvs_one_done;
            4'h9: o = s.dvs_two_done;
            4'ha: o = s.ext_power_en_one;
            4'hb: o = s.ext_power_en_two;
            4'hc: o = s.system_supply_good;
            4'hd: o = s.converter_power_good;
            4'he: o = s.ext_clk_2m;
            4'hf: o = s.aux_reset;
            default: o = 1'b0;
        endcase
        return o;
    endfunction

    function automatic gpc_req_t gpc_route(input logic [3:0] fn,
                                           input logic       a);
        gpc_req_t r;
        r = '0;
        case (fn)
            4'h0, 4'h1: r.gpio_level = a;
            4'h2: r.power_onoff = a;
            4'h3, 4'h4: r.sleep_wake = a;
            4'h5: r.sleep = a;
            4'h6: r.power_on = a;
            4'h7: r.watchdog_rst = a;
            4'h8: r.voltage_scale_select_one = a;
            4'h9: r.voltage_scale_select_two = a;
            4'ha: r.hw_enable_one = a;
            4'hb: r.hw_enable_two = a;
            4'hc, 4'he: r.hw_control_one = a;
            4'hd, 4'hf: r.hw_control_two = a;
            default: r = '0;
        endcase
        return r;
    endfunction

    // ****************************************
    // pin input filters
    // ****************************************
    logic lvl_short;
    logic lvl_long;
    logic [3:0] fn;
    logic pol;
    logic in_active;
    logic out_active;
    logic act;
    logic drv;

    // both filters run all the time so a function change sees a settled level
    gpc_debounce #(.CYC(SHORT_DB_CYC)) u_db_short (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (st_r.sync2),
        .level   (lvl_short)
    );

    gpc_debounce #(.CYC(LONG_DB_CYC)) u_db_long (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (st_r.sync2),
        .level   (lvl_long)
    );

    assign fn         = st_r.ctrl[GPC_FN_HI:0];
    assign pol        = st_r.ctrl[GPC_POL_BIT];
    assign in_active  = st_r.ctrl[GPC_EN_BIT] & st_r.ctrl[GPC_DIR_BIT];
    assign out_active = st_r.ctrl[GPC_EN_BIT] & ~st_r.ctrl[GPC_DIR_BIT];
    assign act  = (gpc_long_fn(fn) ? lvl_long : lvl_short) ~^ pol;
    assign drv  = gpc_out_mux(fn, st_r.out_level, src) ~^ pol;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic       do_wr;
        logic [1:0] sel;
        logic [15:0] wd;
        logic [1:0] sb;
        logic [15:0] m;
        do_wr = 1'b0;
        sel   = st_r.wsel;
        wd    = st_r.wdat;
        sb    = st_r.wstb;
        m     = '0;
        st_nxt = st_r;

        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;

        // write channel: address and data may come in either order
        case (st_r.wr_st)
            GPC_W_IDLE: begin
                if (awvalid && wvalid) begin
                    do_wr = 1'b1;
                    sel   = gpc_decode(awaddr);
                    wd    = wdata[15:0];
                    sb    = wstrb[1:0];
                end else if (awvalid) begin
                    st_nxt.wsel  = gpc_decode(awaddr);
                    st_nxt.wr_st = GPC_W_ADDR;
                end else if (wvalid) begin
                    st_nxt.wdat  = wdata[15:0];
                    st_nxt.wstb  = wstrb[1:0];
                    st_nxt.wr_st = GPC_W_DATA;
                end
            end
            GPC_W_ADDR: begin
                if (wvalid) begin
                    do_wr = 1'b1;
                    wd    = wdata[15:0];
                    sb    = wstrb[1:0];
                end
            end
            GPC_W_DATA: begin
                if (awvalid) begin
                    do_wr = 1'b1;
                    sel   = gpc_decode(awaddr);
                end
            end
            GPC_W_RESP: begin
                if (bready) begin
                    st_nxt.wr_st = GPC_W_IDLE;
                end
            end
            default: st_nxt.wr_st = GPC_W_IDLE;
        endcase

        if (do_wr) begin
            st_nxt.wr_st = GPC_W_RESP;
            st_nxt.bresp = GPC_RESP_OKAY;
            m = {{8{sb[1]}}, {8{sb[0]}}};
            if (sel == GPC_SEL_CTRL) begin
                m = m & GPC_CTRL_WMASK;
                st_nxt.ctrl = (st_r.ctrl & ~m) | (wd & m);
            end else if (sel == GPC_SEL_LEVEL) begin
                if (sb[0]) begin
                    st_nxt.out_level = wd[0];
                end
            end else begin
                // status is read only; unmapped words report an error
                st_nxt.bresp = GPC_RESP_SLVERR;
            end
        end

        // read channel: one word at a time, answer one cycle after address
        if (!st_r.rvalid && arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = GPC_RESP_OKAY;
            st_nxt.rdata  = '0;
            case (gpc_decode(araddr))
                GPC_SEL_CTRL:  st_nxt.rdata[15:0] = st_r.ctrl;
                GPC_SEL_LEVEL: st_nxt.rdata[0] = st_r.out_level;
                GPC_SEL_STAT:  st_nxt.rdata[1:0] = {st_r.sync2, act};
                default:       st_nxt.rresp = GPC_RESP_SLVERR;
            endcase
        end else if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // pad driver; open drain only ever pulls low
        st_nxt.pin_oe = out_active &
                        (~st_r.ctrl[GPC_OD_BIT] | ~drv);
        st_nxt.pin_o  = ~st_r.ctrl[GPC_OD_BIT] & drv;

        // requests and edge events from the filtered, corrected level
        st_nxt.prev = act;
        st_nxt.req  = in_active ? gpc_route(fn, act) : '0;
        if (!in_active) begin
            st_nxt.irq = 1'b0;
        end else if (st_r.ctrl[GPC_MODE_BIT]) begin
            st_nxt.irq = act ^ st_r.prev;
        end else begin
            st_nxt.irq = act & ~st_r.prev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r           <= '0;
            st_r.ctrl      <= GPC_CTRL_RST;
            st_r.wr_st     <= GPC_W_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign awready = (st_r.wr_st == GPC_W_IDLE) ||
                     (st_r.wr_st == GPC_W_DATA);
    assign wready  = (st_r.wr_st == GPC_W_IDLE) ||
                     (st_r.wr_st == GPC_W_ADDR);
    assign bvalid  = (st_r.wr_st == GPC_W_RESP);
    assign bresp   = st_r.bresp;
    assign arready = ~st_r.rvalid;
    assign rvalid  = st_r.rvalid;
    assign rdata   = st_r.rdata;
    assign rresp   = st_r.rresp;
    assign pin_out = st_r.pin_o;
    assign pin_oe  = st_r.pin_oe;
    assign pin_irq = st_r.irq;
    assign req     = st_r.req;
    // reserved pull code leaves both resistors off
    assign pull_up_en   = (st_r.ctrl[GPC_PULL_HI:GPC_PULL_LO] ==
                           GPC_PULL_UP);
    assign pull_down_en = (st_r.ctrl[GPC_PULL_HI:GPC_PULL_LO] ==
                           GPC_PULL_DOWN);
    assign supply_domain_select = st_r.ctrl[GPC_DOM_BIT];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    tristate_off_a: assert property (
        !st_r.ctrl[GPC_EN_BIT] |=> !pin_oe)
        else $error("pin driven while disabled");

    input_no_drive_a: assert property (
        st_r.ctrl[GPC_DIR_BIT] |=> !pin_oe)
        else $error("pin driven while input");

    pull_exclusive_a: assert property (
        !(pull_up_en && pull_down_en))
        else $error("both pull resistors on");

    single_edge_a: assert property (
        in_active && !st_r.ctrl[GPC_MODE_BIT] && !act && st_r.prev
        |=> !pin_irq)
        else $error("interrupt on wrong edge");

    rise_edge_a: assert property (
        in_active && !st_r.ctrl[GPC_MODE_BIT] && act && !st_r.prev
        |=> pin_irq ##1 !pin_irq || $past(st_r.ctrl[GPC_MODE_BIT]))
        else $error("missed active edge interrupt");

    both_edge_a: assert property (
        in_active && st_r.ctrl[GPC_MODE_BIT] && (act != st_r.prev)
        |=> pin_irq)
        else $error("missed edge in both-edge mode");

    open_drain_a: assert property (
        st_r.ctrl[GPC_OD_BIT] |=> !pin_out)
        else $error("open drain drove high");

    level_out_a: assert property (
        out_active && fn == 4'h0 && !st_r.ctrl[GPC_OD_BIT]
        |=> pin_oe && pin_out == ($past(st_r.out_level) ~^ $past(pol)))
        else $error("register level not on pin");

    no_irq_idle_a: assert property (
        !in_active |=> !pin_irq)
        else $error("interrupt while not an input");

    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    irq_seen_c: cover property (pin_irq);
    write_done_c: cover property (bvalid && bready);
    read_done_c: cover property (rvalid && rready);
    od_low_c: cover property (pin_oe && st_r.ctrl[GPC_OD_BIT]);

endmodule

// [gpc_pkg.sv]
// gpc_pkg: constants, states and carrier types of the pin control block
// assumes a single 20 MHz clock domain and an AXI4-Lite register slave

package gpc_pkg;

    // ****************************************
    // register map (word index, byte = 4 * index)
    // ****************************************
    localparam logic [29:0] GPC_CTRL_IDX  = 30'h0000403b;
    localparam logic [29:0] GPC_LEVEL_IDX = 30'h00004080;
    localparam logic [29:0] GPC_STAT_IDX  = 30'h00004081;

    localparam logic [15:0] GPC_CTRL_RST   = 16'ha400;
    localparam logic [15:0] GPC_CTRL_WMASK = 16'hfe8f;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int GPC_DIR_BIT   = 15;
    localparam int GPC_PULL_HI   = 14;
    localparam int GPC_PULL_LO   = 13;
    localparam int GPC_MODE_BIT  = 12;
    localparam int GPC_DOM_BIT   = 11;
    localparam int GPC_POL_BIT   = 10;
    localparam int GPC_OD_BIT    = 9;
    localparam int GPC_EN_BIT    = 7;
    localparam int GPC_FN_HI     = 3;

    localparam logic [1:0] GPC_PULL_DOWN = 2'h1;
    localparam logic [1:0] GPC_PULL_UP   = 2'h2;

    localparam logic [1:0] GPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPC_RESP_SLVERR = 2'h2;

    localparam logic [1:0] GPC_SEL_NONE  = 2'h0;
    localparam logic [1:0] GPC_SEL_CTRL  = 2'h1;
    localparam logic [1:0] GPC_SEL_LEVEL = 2'h2;
    localparam logic [1:0] GPC_SEL_STAT  = 2'h3;

    // debounce lengths in clock cycles
    localparam int GPC_SHORT_DB_CYC = 32;
    localparam int GPC_LONG_DB_CYC  = 2000;

    typedef enum logic [3:0] {
        GPC_W_IDLE = 4'h1,
        GPC_W_ADDR = 4'h2,
        GPC_W_DATA = 4'h4,
        GPC_W_RESP = 4'h8
    } gpc_wr_st_t;

    // functions that an input pin can request
    typedef struct packed {
        logic gpio_level;
        logic power_onoff;
        logic sleep_wake;
        logic sleep;
        logic power_on;
        logic watchdog_rst;
        logic voltage_scale_select_one;
        logic voltage_scale_select_two;
        logic hw_enable_one;
        logic hw_enable_two;
        logic hw_control_one;
        logic hw_control_two;
    } gpc_req_t;

    // device states that an output pin can show
    typedef struct packed {
        logic osc_32k;
        logic on_state;
        logic sleep_state;
        logic power_state_change;
        logic pen_down;
        logic conv_complete;
        logic dvs_one_done;
        logic dvs_two_done;
        logic ext_power_en_one;
        logic ext_power_en_two;
        logic system_supply_good;
        logic converter_power_good;
        logic ext_clk_2m;
        logic aux_reset;
    } gpc_src_t;

    typedef struct packed {
        logic        level;
        logic [15:0] cnt;
    } gpc_db_t;

endpackage

// [gpc_debounce.sv]
// gpc_debounce: holds a level until the input has stayed at a new value
// for CYC consecutive cycles; input must already be synchronised

`timescale 1ns/100ps

module gpc_debounce
    import gpc_pkg::*;
#(
    parameter int CYC = 32
) (
    input  wire logic aclk,     // system clock
    input  wire logic aresetn,  // synchronous reset, active low
    input  wire logic raw,      // synchronised pin level
    output logic      level     // filtered level
);

    localparam logic [15:0] LAST = 16'(CYC - 1);

    gpc_db_t st_r;
    gpc_db_t st_nxt;

    // ****************************************
    // filter
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        if (raw == st_r.level) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= LAST) begin
            st_nxt.level = raw;
            st_nxt.cnt   = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.level;

endmodule

// [gpc_pad_model.sv]
// gpc_pad_model: board side of the pin, resolves the level on the pad
// assumes the bench moves ext_en and ext_lvl just after clock edges

`timescale 1ns/100ps

module gpc_pad_model (
    input  wire logic aclk,          // system clock
    input  wire logic pin_out,       // level the device drives
    input  wire logic pin_oe,        // device drives the pad
    input  wire logic pull_up_en,    // pull-up resistor on
    input  wire logic pull_down_en,  // pull-down resistor on
    input  wire logic ext_en,        // board drives the pad
    input  wire logic ext_lvl,       // level the board drives
    output logic      pin_in         // resolved pad level
);
    // ****************************************
    // pad resolution
    // ****************************************
    // a pad nobody drives or pulls wanders instead of keeping a value
    logic float_r = 1'b0;

    always_ff @(posedge aclk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        if (pin_oe)
            pin_in = pin_out;
        else if (ext_en)
            pin_in = ext_lvl;
        else if (pull_up_en)
            pin_in = 1'b1;
        else if (pull_down_en)
            pin_in = 1'b0;
        else
            pin_in = float_r;
    end
endmodule

// [gpc_pin_ctrl_bench.sv]
// gpc_pin_ctrl_bench: self-checking bench for the pin control block
// assumes short debounce lengths so that each test stays brief

`timescale 1ns/100ps

module gpc_pin_ctrl_bench;
    import gpc_pkg::*;

    // ****************************************
    // signals and instances
    // ****************************************
    localparam logic [31:0] A_CTRL = 32'h000100ec;
    localparam logic [31:0] A_LVL  = 32'h00010200;
    localparam logic [31:0] A_STAT = 32'h00010204;
    localparam logic [31:0] A_NONE = 32'h00000ff0;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
    logic        supply_domain_select, pin_irq, ext_en, ext_lvl;
    gpc_src_t    src;
    gpc_req_t    req;
    int          err_count, total_checks, cyc, irq_n, base;
    int          req_bit[16] = '{11, 11, 10, 9, 9, 8, 7, 6, 5, 4, 3, 2,
                                 1, 0, 1, 0};

    gpc_pin_ctrl #(.SHORT_DB_CYC(2), .LONG_DB_CYC(4)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out,
        .pin_oe, .pull_up_en, .pull_down_en, .supply_domain_select,
        .src, .req, .pin_irq);

    gpc_pad_model i_pad (
        .aclk, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_en,
        .ext_lvl, .pin_in);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // the cycle counter cyc is the hang guard, irq_n the pulse tally
    always @(posedge aclk) begin
        cyc++;
        if (pin_irq === 1'b1)
            irq_n++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp; bready <= 1'b0; got = 1'b1;
            end
        end
    endtask

    task automatic rdr(input logic [31:0] a);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata; resp = rresp; rready <= 1'b0; got = 1'b1;
            end
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [1:0] pulls[4] = '{2'b00, 2'b01, 2'b10, 2'b00};
        rdr(A_CTRL);
        chk("ctrl_reset", rd, 32'h0000a400);
        chk("pins_reset", {pin_oe, pull_up_en, pull_down_en,
            supply_domain_select}, 4'b0010);
        wr(A_CTRL, 32'hffffffff);
        chk("wr_okay", resp, GPC_RESP_OKAY);
        rdr(A_CTRL);
        chk("rd_okay", resp, GPC_RESP_OKAY);
        chk("ctrl_mask", rd, 32'h0000fe8f);
        chk("dom_sel", supply_domain_select, 1'b1);
        for (int p = 0; p < 4; p++) begin
            wr(A_CTRL, 32'(p) << 13);
            wait_n(3);
            chk("pulls", {pull_up_en, pull_down_en, pin_oe},
                {pulls[p], 1'b0});
        end
        wr(A_NONE, 32'h1);
        chk("unmapped_wr", resp, GPC_RESP_SLVERR);
        wr(A_STAT, 32'h1);
        chk("status_wr", resp, GPC_RESP_SLVERR);
        rdr(A_NONE);
        chk("unmapped_rd", rd, 32'h0);
        chk("unmapped_rresp", resp, GPC_RESP_SLVERR);
        $display("test regs done");
    endtask

    task automatic t_out();
        logic [13:0] sel;
        for (int fn = 0; fn < 16; fn++) begin
            sel = (fn < 5) ? 14'h1 << (14 - fn) : 14'h1 << (15 - fn);
            if (fn == 5) sel = '1;
            wr(A_CTRL, 32'h2480 | fn);
            if (fn == 0) wr(A_LVL, 32'h1);
            src <= gpc_src_t'(sel);
            wait_n(3);
            chk("out_hi", {pin_oe, pin_out}, {1'b1, fn != 5});
            if (fn == 0) wr(A_LVL, 32'h0);
            src <= gpc_src_t'(~sel);
            wait_n(3);
            chk("out_lo", {pin_oe, pin_out}, 2'b10);
        end
        wr(A_CTRL, 32'h2080);
        wait_n(3);
        chk("out_inverted", pin_out, 1'b1);
        wr(A_CTRL, 32'h2680);
        wait_n(3);
        chk("od_low", {pin_oe, pin_out}, 2'b10);
        wr(A_LVL, 32'h1);
        wait_n(3);
        chk("od_high", pin_oe, 1'b0);
        wr(A_CTRL, 32'h2400);
        wait_n(3);
        chk("out_disabled", pin_oe, 1'b0);
        $display("test out done");
    endtask

    task automatic t_in();
        ext_lvl <= 1'b0;
        ext_en <= 1'b1;
        for (int fn = 0; fn < 16; fn++) begin
            wr(A_CTRL, 32'ha480 | fn);
            wait_n(12);
            ext_lvl <= 1'b1;
            wait_n(12);
            chk("req_hi", req, 12'h1 << req_bit[fn]);
            chk("in_oe", pin_oe, 1'b0);
            ext_lvl <= 1'b0;
            wait_n(12);
            chk("req_lo", req, 12'h0);
        end
        wr(A_CTRL, 32'ha401);
        ext_lvl <= 1'b1;
        wait_n(12);
        chk("in_disabled", {req, pin_oe}, 13'h0);
        // status word: bit1 raw synced pin, bit0 filtered corrected level
        rdr(A_STAT);
        chk("stat_resp", resp, GPC_RESP_OKAY);
        chk("stat_rd", rd, 32'h00000003);
        $display("test in done");
    endtask

    task automatic t_irq();
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            ext_lvl <= 1'b0;
            wr(A_CTRL, 32'ha081 | (32'(k[1]) << 12) | (32'(k[0]) << 10));
            wait_n(12);
            base = irq_n;
            ext_lvl <= 1'b1;
            wait_n(12);
            chk("irq_rise", irq_n - base, k[1] | k[0]);
            base = irq_n;
            ext_lvl <= 1'b0;
            wait_n(12);
            chk("irq_fall", irq_n - base, {31'h0, k[1] | ~k[0]});
        end
        $display("test irq done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = '0; wdata = '0;
        araddr = '0; wstrb = 4'hf; src = '0; ext_en = 1'b0;
        ext_lvl = 1'b0; err_count = 0; total_checks = 0; cyc = 0;
        irq_n = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_irq();
        close_out();
    end
endmodule
